// ==== inc/trrc_pkg.sv ====
// Package of constants and types for the transmit retry and rate control block
package trrc_pkg;

	// Register byte offsets
	localparam logic [7:0] TRRC_CFG_OFS = 8'h00;
	localparam logic [7:0] TRRC_RETRY_OFS = 8'h04;
	localparam logic [7:0] TRRC_BURST_OFS = 8'h08;
	localparam logic [7:0] TRRC_MSGIV_OFS = 8'h0c;
	localparam logic [7:0] TRRC_STATUS_OFS = 8'h10;
	localparam logic [7:0] TRRC_DROPS_OFS = 8'h14;
	localparam logic [7:0] TRRC_REQ_OFS = 8'h18;

	// CFG fields
	localparam int TRRC_CFG_AM_EN_BIT = 0;
	localparam int TRRC_CFG_SWR_EN_BIT = 1;
	localparam int TRRC_CFG_BURST_EN_BIT = 2;
	localparam int TRRC_CFG_MAXLVL_LSB = 4;
	localparam int TRRC_CFG_WEIGHT_LSB = 8;
	// RETRY fields
	localparam int TRRC_RETRY_HW_LSB = 0;
	localparam int TRRC_RETRY_SW_LSB = 4;

	// Reset values and legal limits
	localparam logic TRRC_AM_EN_RST = 1'b1;
	localparam logic TRRC_SWR_EN_RST = 1'b0;
	localparam logic TRRC_BURST_EN_RST = 1'b1;
	localparam logic [2:0] TRRC_MAXLVL_RST = 3'h7;
	localparam logic signed [6:0] TRRC_WEIGHT_RST = 7'sh05;
	localparam logic signed [6:0] TRRC_WEIGHT_MIN = -7'sh01;
	localparam logic signed [6:0] TRRC_WEIGHT_MAX = 7'sh20;
	localparam logic [3:0] TRRC_HW_RETRY_RST = 4'ha;
	localparam logic [3:0] TRRC_HW_RETRY_MIN = 4'h1;
	localparam logic [3:0] TRRC_SW_RETRY_RST = 4'h3;
	localparam logic [3:0] TRRC_SW_RETRY_MAX = 4'he;
	localparam logic [3:0] TRRC_BURST_MS_RST = 4'h5;
	localparam logic [3:0] TRRC_BURST_MS_MIN = 4'h1;
	localparam logic [3:0] TRRC_BURST_MS_MAX = 4'ha;
	localparam logic [11:0] TRRC_MSGIV_S_RST = 12'h004;
	localparam logic [11:0] TRRC_MSGIV_S_MIN = 12'h001;
	localparam logic [11:0] TRRC_MSGIV_S_MAX = 12'he10;

	// Timing
	localparam int TRRC_CLK_MHZ = 100;
	localparam int TRRC_MS_NS = 1000000;
	localparam int TRRC_CLK_NS = 1000 / TRRC_CLK_MHZ;
	localparam int TRRC_MS_CYCLES = TRRC_MS_NS / TRRC_CLK_NS;

	// Peer SNR must beat the local average by more than this before the level steps up
	localparam logic [7:0] TRRC_SNR_UP_MARGIN = 8'h02;

	typedef enum logic [3:0] {
		TRRC_IDLE = 4'b0001,
		TRRC_SEND = 4'b0010,
		TRRC_WAIT = 4'b0100,
		TRRC_DONE = 4'b1000
	} trrc_state_t;

endpackage : trrc_pkg

// ==== hdl/trrc_core.sv ====
// Transmit retry, modulation and burst control with AXI4-Lite configuration
`timescale 1ns/10ps
// Behaviour
// R1: History weight -1..32, default 5; -1 makes average equal the newest SNR.
// R2: Larger weight gives the previous average more influence; updated per data frame.
// R3: Average received SNR goes out in every modulation information message.
// R4: Without software retries, drop frame when failed retransmissions reach the hardware limit.
// R5: During a burst, shorten spacing and send frames back to back, no contention.
// R6: Burst enabled by default; burst length 1..10 ms, default 5 ms.
// R7: First attempt of each new frame uses the decided modulation level.
// R8: Hardware retransmissions keep the same level, up to the hardware retry limit.
// R9: With software retries on, an exhausted frame is requeued at the tail; the code also requires adaptive modulation on, and drops the frame otherwise.
// R10: Requeue also moves all other queued frames for the same destination.
// R11: Each new retrial sequence takes a fresh level and up to the hardware limit.
// R12: At most the configured software retrial sequences (0..14, default 3), then drop.
// R13: Adaptive level varies between 1 and configured maximum; maximum 1 fixes it.
// R14: Software retry setting resets disabled; level changes between sequences only when on.
// R15: Information messages spaced by at least 1..3600 s, default 4 s.
// R16: Decision uses peer SNR report, time since last send, and success history.
// R17: Software configuring the block should keep software retries off while burst is on.
// R18: Adaptive modulation off sends at the configured maximum, default level 7.
// R19: New average = (weight*average + sample) / (weight+1), per received data frame.
module trrc_core
	import trrc_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = 100000000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Received data frame SNR
	input wire logic rx_snr_valid,
	input wire logic [7:0] rx_snr,
	// SNR report from the peer
	input wire logic peer_snr_valid,
	input wire logic [7:0] peer_snr,
	// Frame from the transmit queue
	input wire logic frame_valid,
	output logic frame_ready,
	input wire logic [47:0] frame_dest,
	// Radio transmitter
	output logic tx_start,
	output logic [2:0] tx_level,
	output logic tx_short_ifs,
	output logic tx_no_contend,
	input wire logic tx_done,
	input wire logic tx_acked,
	// Frame fate: sent, dropped, or requeued with all same-destination frames
	output logic frame_sent,
	output logic frame_drop,
	output logic requeue_req,
	output logic [47:0] requeue_dest,
	// Information message to peer
	output logic info_msg_valid,
	output logic [7:0] info_msg_snr,
	input wire logic info_msg_ready
);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic am_en_reg;
	logic swr_en_reg;
	logic burst_en_reg;
	logic [2:0] max_level_reg;
	logic signed [6:0] weight_reg;
	logic [3:0] hw_limit_reg;
	logic [3:0] sw_limit_reg;
	logic [3:0] burst_ms_reg;
	logic [11:0] msg_iv_reg;
	logic [15:0] drops_reg;
	logic [7:0] avg_snr_reg;
	logic [2:0] level_reg;
	logic [3:0] sw_count_reg;

	logic aw_done_reg;
	logic w_done_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wr_fire;
	logic [31:0] wr_val;

	assign s_axi_awready = !aw_done_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_done_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_done_reg && w_done_reg && !s_axi_bvalid;
	assign wr_val = wdata_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_done_reg <= 1'b0;
			w_done_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done_reg <= 1'b1;
				// Partial strobes are honoured per lane against zero
				for (int i = 0; i < 4; i++) begin
					wdata_reg[i*8 +: 8] <= s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : 8'h00;
				end
			end
			if (wr_fire) begin
				aw_done_reg <= 1'b0;
				w_done_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg <= TRRC_REQ_OFS && awaddr_reg[1:0] == 2'h0) ?
					2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Out-of-range values are ignored so the settings stay legal
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			am_en_reg <= TRRC_AM_EN_RST;
			swr_en_reg <= TRRC_SWR_EN_RST; // R14
			burst_en_reg <= TRRC_BURST_EN_RST; // R6
			max_level_reg <= TRRC_MAXLVL_RST; // R18
			weight_reg <= TRRC_WEIGHT_RST; // R1
			hw_limit_reg <= TRRC_HW_RETRY_RST; // R4
			sw_limit_reg <= TRRC_SW_RETRY_RST; // R12
			burst_ms_reg <= TRRC_BURST_MS_RST; // R6
			msg_iv_reg <= TRRC_MSGIV_S_RST; // R15
		end else if (clk_en && wr_fire) begin
			unique case (awaddr_reg)
				TRRC_CFG_OFS: begin
					am_en_reg <= wr_val[TRRC_CFG_AM_EN_BIT];
					swr_en_reg <= wr_val[TRRC_CFG_SWR_EN_BIT];
					burst_en_reg <= wr_val[TRRC_CFG_BURST_EN_BIT];
					if (wr_val[TRRC_CFG_MAXLVL_LSB +: 3] != 3'h0)
						max_level_reg <= wr_val[TRRC_CFG_MAXLVL_LSB +: 3];
					if ($signed(wr_val[TRRC_CFG_WEIGHT_LSB +: 7]) >= TRRC_WEIGHT_MIN &&
						$signed(wr_val[TRRC_CFG_WEIGHT_LSB +: 7]) <= TRRC_WEIGHT_MAX)
						weight_reg <= $signed(wr_val[TRRC_CFG_WEIGHT_LSB +: 7]); // R1
				end
				TRRC_RETRY_OFS: begin
					if (wr_val[TRRC_RETRY_HW_LSB +: 4] >= TRRC_HW_RETRY_MIN)
						hw_limit_reg <= wr_val[TRRC_RETRY_HW_LSB +: 4];
					if (wr_val[TRRC_RETRY_SW_LSB +: 4] <= TRRC_SW_RETRY_MAX)
						sw_limit_reg <= wr_val[TRRC_RETRY_SW_LSB +: 4];
				end
				TRRC_BURST_OFS: begin
					if (wr_val[3:0] >= TRRC_BURST_MS_MIN && wr_val[3:0] <= TRRC_BURST_MS_MAX)
						burst_ms_reg <= wr_val[3:0]; // R6
				end
				TRRC_MSGIV_OFS: begin
					if (wr_val[11:0] >= TRRC_MSGIV_S_MIN && wr_val[11:0] <= TRRC_MSGIV_S_MAX)
						msg_iv_reg <= wr_val[11:0]; // R15
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				unique case (s_axi_araddr)
					TRRC_CFG_OFS: s_axi_rdata <= {17'h00000, weight_reg, 1'b0, max_level_reg,
						1'b0, burst_en_reg, swr_en_reg, am_en_reg};
					TRRC_RETRY_OFS: s_axi_rdata <= {24'h000000, sw_limit_reg, hw_limit_reg};
					TRRC_BURST_OFS: s_axi_rdata <= {28'h0000000, burst_ms_reg};
					TRRC_MSGIV_OFS: s_axi_rdata <= {20'h00000, msg_iv_reg};
					TRRC_STATUS_OFS: s_axi_rdata <= {9'h000, sw_count_reg, level_reg, avg_snr_reg,
						8'h00};
					TRRC_DROPS_OFS: s_axi_rdata <= {16'h0000, drops_reg};
					TRRC_REQ_OFS: s_axi_rdata <= 32'h00000000;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Average SNR

	logic [13:0] avg_num;
	logic [5:0] avg_den;
	assign avg_num = 14'(weight_reg[5:0]) * 14'(avg_snr_reg) + 14'(rx_snr);
	assign avg_den = 6'(weight_reg[5:0]) + 6'h01;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			avg_snr_reg <= 8'h00;
		end else if (clk_en && rx_snr_valid) begin
			if (weight_reg < 7'sh00)
				avg_snr_reg <= rx_snr; // R1
			else
				avg_snr_reg <= 8'(avg_num / 14'(avg_den)); // R2 R19
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Modulation decision from peer SNR, idle time and success history

	logic [7:0] peer_snr_reg;
	logic [3:0] fail_hist_reg;
	logic [2:0] decided_level;
	logic stale_link;
	logic [31:0] idle_cnt_reg;

	assign stale_link = idle_cnt_reg >= SEC_CYCLES;

	always_comb begin
		decided_level = max_level_reg;
		if (am_en_reg) begin
			decided_level = level_reg; // R16
			if (fail_hist_reg[1:0] == 2'b11 || stale_link) begin
				if (level_reg > 3'h1)
					decided_level = level_reg - 3'h1;
			end else if (fail_hist_reg == 4'h0 &&
				9'(peer_snr_reg) > 9'(avg_snr_reg) + 9'(TRRC_SNR_UP_MARGIN) &&
				level_reg < max_level_reg) begin
				decided_level = level_reg + 3'h1;
			end
			if (decided_level > max_level_reg)
				decided_level = max_level_reg; // R13
			if (decided_level == 3'h0)
				decided_level = 3'h1; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit sequencer

	trrc_state_t state_reg;
	logic [3:0] hw_count_reg;
	logic [47:0] dest_reg;
	logic [31:0] burst_cnt_reg;
	logic burst_live;
	logic seq_exhausted;

	assign frame_ready = (state_reg == TRRC_IDLE);
	assign seq_exhausted = hw_count_reg >= hw_limit_reg;
	assign burst_live = burst_en_reg && burst_cnt_reg != 32'h0;
	assign tx_short_ifs = burst_live; // R5
	assign tx_no_contend = burst_live; // R5

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= TRRC_IDLE;
			hw_count_reg <= 4'h0;
			sw_count_reg <= 4'h0;
			dest_reg <= 48'h000000000000;
			level_reg <= TRRC_MAXLVL_RST;
			tx_level <= TRRC_MAXLVL_RST;
			tx_start <= 1'b0;
			frame_sent <= 1'b0;
			frame_drop <= 1'b0;
			requeue_req <= 1'b0;
			requeue_dest <= 48'h000000000000;
			fail_hist_reg <= 4'h0;
			drops_reg <= 16'h0000;
		end else if (clk_en) begin
			tx_start <= 1'b0;
			frame_sent <= 1'b0;
			frame_drop <= 1'b0;
			requeue_req <= 1'b0;
			unique case (state_reg)
				TRRC_IDLE: begin
					if (frame_valid) begin
						dest_reg <= frame_dest;
						hw_count_reg <= 4'h0;
						sw_count_reg <= 4'h0;
						level_reg <= am_en_reg ? decided_level : max_level_reg; // R7 R18
						state_reg <= TRRC_SEND;
					end
				end
				TRRC_SEND: begin
					tx_start <= 1'b1;
					tx_level <= level_reg; // R8
					state_reg <= TRRC_WAIT;
				end
				TRRC_WAIT: begin
					if (tx_done) begin
						fail_hist_reg <= {fail_hist_reg[2:0], !tx_acked}; // R16
						if (tx_acked) begin
							frame_sent <= 1'b1;
							state_reg <= TRRC_DONE;
						end else if (!seq_exhausted) begin
							hw_count_reg <= hw_count_reg + 4'h1; // R8
							state_reg <= TRRC_SEND;
						end else if (am_en_reg && swr_en_reg && sw_count_reg < sw_limit_reg) begin
							requeue_req <= 1'b1; // R9
							requeue_dest <= dest_reg; // R10
							sw_count_reg <= sw_count_reg + 4'h1; // R12
							hw_count_reg <= 4'h0; // R11
							level_reg <= decided_level; // R11 R14
							state_reg <= TRRC_SEND;
						end else begin
							frame_drop <= 1'b1; // R4 R12
							drops_reg <= drops_reg + 16'h0001;
							state_reg <= TRRC_DONE;
						end
					end
				end
				TRRC_DONE: begin
					state_reg <= TRRC_IDLE;
				end
				default: state_reg <= TRRC_IDLE;
			endcase
		end
	end

	// Burst window opens on a send and closes after the burst period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_cnt_reg <= 32'h0;
			idle_cnt_reg <= 32'h0;
			peer_snr_reg <= 8'h00;
		end else if (clk_en) begin
			if (tx_start && burst_cnt_reg == 32'h0)
				burst_cnt_reg <= 32'(burst_ms_reg) * 32'(TRRC_MS_CYCLES); // R6
			else if (burst_cnt_reg != 32'h0)
				burst_cnt_reg <= burst_cnt_reg - 32'h1;
			if (tx_start)
				idle_cnt_reg <= 32'h0;
			else if (!stale_link)
				idle_cnt_reg <= idle_cnt_reg + 32'h1;
			if (peer_snr_valid)
				peer_snr_reg <= peer_snr; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Information message pacing

	logic [31:0] sec_cnt_reg;
	logic [11:0] iv_cnt_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_cnt_reg <= 32'h0;
			iv_cnt_reg <= 12'h000;
			info_msg_valid <= 1'b0;
			info_msg_snr <= 8'h00;
		end else if (clk_en) begin
			if (info_msg_valid) begin
				if (info_msg_ready) begin
					info_msg_valid <= 1'b0;
					iv_cnt_reg <= 12'h000;
					sec_cnt_reg <= 32'h0;
				end
			end else if (iv_cnt_reg >= msg_iv_reg) begin
				info_msg_valid <= 1'b1; // R15
				info_msg_snr <= avg_snr_reg; // R3
			end else if (sec_cnt_reg >= SEC_CYCLES - 1) begin
				sec_cnt_reg <= 32'h0;
				iv_cnt_reg <= iv_cnt_reg + 12'h001;
			end else begin
				sec_cnt_reg <= sec_cnt_reg + 32'h1;
			end
		end
	end

endmodule : trrc_core

// ==== tb/trrc_radio_model.sv ====
// Behavioural radio transmitter and peer message sink
`timescale 1ns/10ps
module trrc_radio_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_start,
	input wire logic fail_all,
	output logic tx_done,
	output logic tx_acked,
	input wire logic info_msg_valid,
	output logic info_msg_ready
);
	int cnt;
	int seed = 82;
	// Ack line toggles every cycle outside the done pulse so a stale value is never read as valid
	always_ff @(posedge aclk) begin
		tx_done <= 1'b0;
		tx_acked <= ~tx_acked;
		info_msg_ready <= info_msg_valid && !info_msg_ready;
		if (!aresetn) begin
			cnt <= 0;
			tx_acked <= 1'b0;
		end else if (tx_start) begin
			cnt <= 1 + int'($unsigned($random(seed)) % 4);
		end else if (cnt == 1) begin
			cnt <= 0;
			tx_done <= 1'b1;
			tx_acked <= !fail_all;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule : trrc_radio_model

// ==== tb/trrc_core_asserts.sv ====
// Concurrent checks on the transmit retry and rate control ports
`timescale 1ns/10ps
module trrc_core_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire logic tx_start,
	input wire logic [2:0] tx_level,
	input wire logic tx_short_ifs,
	input wire logic tx_no_contend,
	input wire logic tx_done,
	input wire logic tx_acked,
	input wire logic frame_sent,
	input wire logic frame_drop,
	input wire logic requeue_req,
	input wire logic info_msg_valid,
	input wire logic info_msg_ready,
	input wire logic [7:0] info_msg_snr
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_start_after_take: assert property (frame_valid && frame_ready |-> ##2 tx_start)
		else $error("no attempt two cycles after frame taken");
	a_level_legal: assert property (tx_start |-> tx_level != 3'h0)
		else $error("attempt at level zero");
	a_burst_pair: assert property (tx_short_ifs == tx_no_contend)
		else $error("short spacing and no contention disagree");
	a_info_holds: assert property (info_msg_valid && !info_msg_ready |=>
		info_msg_valid && $stable(info_msg_snr))
		else $error("info message dropped or changed before taken");
	a_fate_single: assert property ($onehot0({frame_sent, frame_drop, requeue_req}))
		else $error("two frame fates at once");
	a_ack_sends: assert property (tx_done && tx_acked |=> frame_sent)
		else $error("acked attempt not reported sent");
	a_busy_no_take: assert property (tx_start |-> !frame_ready)
		else $error("new frame accepted during attempt");
	a_requeue_retry: assert property (requeue_req |-> ##[1:8] tx_start)
		else $error("no new sequence after requeue");
	c_requeue: cover property (requeue_req);
	c_drop: cover property (frame_drop);
	c_info: cover property (info_msg_valid && info_msg_ready);
endmodule : trrc_core_asserts

bind trrc_core trrc_core_asserts u_chk (.*);

// ==== tb/testbench.sv ====
// Self-checking bench for the transmit retry and rate control block
`timescale 1ns/10ps
module testbench;
	import trrc_pkg::*;
	localparam int SECS = 100;
	localparam int MIN_GAP = int'(TRRC_MSGIV_S_RST) * SECS;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rx_snr_valid, peer_snr_valid, frame_valid, frame_ready, tx_start, tx_short_ifs;
	logic tx_no_contend, tx_done, tx_acked, frame_sent, frame_drop, requeue_req, fail_all;
	logic info_msg_valid, info_msg_ready, chk_avg, clk_en, bst;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx_snr, peer_snr, info_msg_snr, s, t, av;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] tx_level, fix_lvl;
	logic [47:0] frame_dest, requeue_dest;
	logic [65:0] busq[$];
	logic [49:0] fateq[$];
	int err_total, total_checks, seed, starts, drops, gap, msgs;

	trrc_core #(.SEC_CYCLES(SECS)) DUT (.*);
	trrc_radio_model u_radio (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [65:0] seen, input logic [65:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			$display("BAD %0t wait ran out", $time);
			conclude();
		end
	endtask : tmo

	// Master holds bready from the start; slave may take address and data in any order
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		busq.push_back({r, 64'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(n, 50);
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		int n;
		busq.push_back({r, d & m, m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		tmo(n, 50);
		@(posedge aclk);
	endtask : rd

	function automatic logic [31:0] cfg(input logic am, sw, bu, input logic [2:0] lv,
		input logic [6:0] w);
		return {17'h0, w, 1'b0, lv, 1'b0, bu, sw, am};
	endfunction : cfg

	task automatic snr(input logic [7:0] v);
		rx_snr <= v;
		rx_snr_valid <= 1'b1;
		peer_snr <= 8'($random(seed));
		peer_snr_valid <= 1'b1;
		@(posedge aclk);
		rx_snr_valid <= 1'b0;
		peer_snr_valid <= 1'b0;
		@(posedge aclk);
	endtask : snr

	// Fate codes: 0 sent, 1 dropped, 2 requeued
	task automatic frame(input logic f, input int nrq, input int nst);
		int n, s0;
		logic [47:0] d;
		d = 48'({$random(seed), $random(seed)});
		for (n = 0; n < nrq; n++) fateq.push_back({2'd2, d});
		fateq.push_back({f ? 2'd1 : 2'd0, d});
		drops += int'(f);
		s0 = starts;
		fail_all <= f;
		frame_dest <= d;
		frame_valid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (frame_ready) break;
		end
		frame_valid <= 1'b0;
		tmo(n, 50);
		for (n = 0; n < 3000 && fateq.size() > 0; n++) @(posedge aclk);
		tmo(n, 3000);
		check(66'(starts - s0), 66'(nst), "attempts");
		@(posedge aclk);
	endtask : frame

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		logic [65:0] e;
		logic [49:0] g;
		if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 64'h0}, busq.pop_front(), "bresp");
		if (s_axi_rvalid && s_axi_rready) begin
			e = busq.pop_front();
			check({s_axi_rresp, s_axi_rdata & e[31:0], e[31:0]}, e, "read");
		end
		if (frame_sent || frame_drop || requeue_req) begin
			g = fateq.pop_front();
			check({frame_drop ? 2'd1 : requeue_req ? 2'd2 : 2'd0,
				requeue_req ? requeue_dest : g[47:0]}, g, "fate");
		end
		if (tx_start) starts++;
		if (tx_start && fix_lvl != 3'h0) check(tx_level, fix_lvl, "level");
		// The window opens on the first send and outlasts the run
		if (tx_start && starts > 1)
			check({tx_short_ifs, tx_no_contend}, {2{bst}}, "burst");
		if (info_msg_valid && info_msg_ready && clk_en) begin
			if (msgs > 0) check(gap >= MIN_GAP, 1'b1, "spacing");
			if (chk_avg) check(info_msg_snr, av, "msg snr");
			msgs++;
			gap = 0;
		end else
			gap++;
	end

	initial begin
		int n, m0;
		seed = 82;
		{err_total, total_checks, starts, drops, gap, msgs} = '0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{rx_snr_valid, peer_snr_valid, frame_valid, fail_all, chk_avg} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_snr, peer_snr, frame_dest, fix_lvl} = '0;
		s_axi_wstrb = 4'hf;
		av = 8'h0;
		clk_en = 1'b1;
		bst = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(TRRC_CFG_OFS, 32'h575, 32'h7f77, 2'b00);
		rd(TRRC_RETRY_OFS, 32'h3a, 32'hff, 2'b00);
		rd(TRRC_MSGIV_OFS, 32'h4, 32'hfff, 2'b00);
		rd(8'h40, 32'h0, 32'h0, 2'b10);
		rd(8'h02, 32'h0, 32'h0, 2'b10);
		wr(8'h40, 32'h1, 2'b10);
		// Out-of-range values must leave the old setting in place
		wr(TRRC_BURST_OFS, 32'h0, 2'b00);
		wr(TRRC_RETRY_OFS, 32'hf0, 2'b00);
		wr(TRRC_MSGIV_OFS, 32'h0, 2'b00);
		rd(TRRC_BURST_OFS, 32'h5, 32'hf, 2'b00);
		rd(TRRC_MSGIV_OFS, 32'h4, 32'hfff, 2'b00);
		rd(TRRC_RETRY_OFS, 32'h3a, 32'hff, 2'b00);
		$display("test registers done");
		wr(TRRC_RETRY_OFS, 32'h12, 2'b00);
		frame(1'b0, 0, 1);
		frame(1'b1, 0, 3);
		// Burst is switched off in the same write that turns software retries on
		bst = 1'b0;
		wr(TRRC_CFG_OFS, cfg(1'b1, 1'b1, 1'b0, 3'h7, 7'h05), 2'b00);
		frame(1'b1, 1, 6);
		wr(TRRC_RETRY_OFS, 32'h02, 2'b00);
		frame(1'b1, 0, 3);
		$display("test retries done");
		bst = 1'b1;
		wr(TRRC_CFG_OFS, cfg(1'b0, 1'b0, 1'b1, 3'h5, 7'h05), 2'b00);
		fix_lvl <= 3'h5;
		frame(1'b1, 0, 3);
		wr(TRRC_CFG_OFS, cfg(1'b1, 1'b0, 1'b1, 3'h1, 7'h05), 2'b00);
		fix_lvl <= 3'h1;
		frame(1'b1, 0, 3);
		fix_lvl <= 3'h0;
		rd(TRRC_DROPS_OFS, 32'(drops), 32'hffff, 2'b00);
		$display("test levels done");
		wr(TRRC_CFG_OFS, cfg(1'b1, 1'b0, 1'b1, 3'h7, 7'h7f), 2'b00);
		s = 8'($random(seed)) & 8'hfe;
		t = 8'($random(seed)) & 8'hfe;
		snr(t);
		snr(s);
		rd(TRRC_STATUS_OFS, {16'h0, s, 8'h0}, 32'hff00, 2'b00);
		wr(TRRC_CFG_OFS, cfg(1'b1, 1'b0, 1'b1, 3'h7, 7'h01), 2'b00);
		snr(t);
		av = 8'((9'(s) + 9'(t)) >> 1);
		rd(TRRC_STATUS_OFS, {16'h0, av, 8'h0}, 32'hff00, 2'b00);
		// A sample offered while frozen must not reach the average
		clk_en <= 1'b0;
		snr(~av);
		clk_en <= 1'b1;
		rd(TRRC_STATUS_OFS, {16'h0, av, 8'h0}, 32'hff00, 2'b00);
		m0 = msgs;
		for (n = 0; n < 1000 && msgs < m0 + 1; n++) @(posedge aclk);
		tmo(n, 1000);
		chk_avg <= 1'b1;
		for (n = 0; n < 1000 && msgs < m0 + 2; n++) @(posedge aclk);
		tmo(n, 1000);
		chk_avg <= 1'b0;
		$display("test average done");
		conclude();
	end
endmodule : testbench
